// [hdl/sadc_regs.svh]
// Timing constants for the subranging converter correction logic.
// Assumes a 25 MHz core clock; all counts derive from nanosecond figures.
`ifndef SADC_REGS_SVH
`define SADC_REGS_SVH

`define SADC_CLK_NS 40
`define SADC_OSC_MHZ 20
`define SADC_OSC_NS (1000 / `SADC_OSC_MHZ)
// Stage period of the shift register, rounded down, at least one cycle
`define SADC_STAGE_CYC ((`SADC_OSC_NS / `SADC_CLK_NS) < 1 ? 1 : (`SADC_OSC_NS / `SADC_CLK_NS))
`define SADC_CONV_NS 67
// Least time, rounded up
`define SADC_CONV_CYC ((`SADC_CONV_NS + `SADC_CLK_NS - 1) / `SADC_CLK_NS)
`define SADC_SETUP_NS 6
`define SADC_CMD_MIN_NS 10
`define SADC_CMD_DUTY_PCT 80
`define SADC_PAD_BITS 5
`define SADC_WORD_BITS 12
`define SADC_CODE_BITS 7
`define SADC_ALL_ONES 12'hFFF
`define SADC_BUF_DEPTH 2

`endif

// [hdl/sadc_pkg.sv]
// Types shared by the converter correction logic.
// Used by the core module; holds no logic.
package sadc_pkg;
    typedef logic [6:0] sadc_code_type;
    typedef logic [11:0] sadc_word_type;
    typedef logic [1:0] sadc_lat_type;
    typedef enum logic [1:0] {LK_IDLE, LK_DRIVE, LK_STROBE, LK_DONE} sadc_link_state_type;
endpackage

// [hdl/sadc_core.sv]
// Digital timing and error correction of a two-step subranging converter.
// Assumes encoder codes, convert command and selects arrive as pins; the
// external latch runs on LINK_CLK and signals readiness on LATCH_READY.
//
// Operation
// - Three-stage shift register, restarted by each convert, paces conversion.
// - Convert command is edge detected; source keeps widths in range.
// - Sample/hold gate equals command period minus the 67 ns conversion interval, rounded up to two cycles.
// - Blanking holds from acquisition start until coarse result is latched.
// - Coarse and fine codes each land in their own 7-bit latch.
// - Both latches merge into one 14-bit latch after the fine strobe.
// - The 14-bit latch feeds a 12-bit adder forming the output word.
// - Coarse code sits in the top seven bits, five zeros below.
// - Fine code sits in the low seven bits, five zeros above.
// - Sum beyond 12 bits saturates to all ones, never wraps.
// - A word-ready pulse marks capture; the latch uses it to load.
// - Word-ready rises only after the data bits have settled.
// - Two selects pick latency of one, two or three convert periods.
// - Invert input selects straight binary or inverted coding.
`include "sadc_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module sadc_core
(
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic LINK_CLK,
    input wire logic CONVERT_CMD,
    input wire sadc_pkg::sadc_code_type COARSE_CODE,
    input wire sadc_pkg::sadc_code_type FINE_CODE,
    input wire sadc_pkg::sadc_lat_type LATENCY_SEL,
    input wire logic OUTPUT_INVERT,
    input wire logic LATCH_READY,
    output logic SH_GATE,
    output logic BLANK,
    output logic WORD_ACCEPT_READY,
    output sadc_pkg::sadc_word_type DATA_OUT,
    output logic WORD_READY_STROBE
);
    import sadc_pkg::*;

    // Pin synchronisers, core domain
    logic cmd_s1_r, cmd_s2_r, cmd_s3_r;
    sadc_code_type coarse_s1_r, coarse_s2_r;
    sadc_code_type fine_s1_r, fine_s2_r;
    sadc_lat_type lat_s1_r, lat_s2_r;
    logic inv_s1_r, inv_s2_r;

    always_ff @(posedge CLOCK)
    begin
        cmd_s1_r <= CONVERT_CMD;
        cmd_s2_r <= cmd_s1_r;
        cmd_s3_r <= cmd_s2_r;
        coarse_s1_r <= COARSE_CODE;
        coarse_s2_r <= coarse_s1_r;
        fine_s1_r <= FINE_CODE;
        fine_s2_r <= fine_s1_r;
        lat_s1_r <= LATENCY_SEL;
        lat_s2_r <= lat_s1_r;
        inv_s1_r <= OUTPUT_INVERT;
        inv_s2_r <= inv_s1_r;
    end

    // Rising edge only, so any width that survives two samples triggers once.
    // Limitation: at this clock a pulse under one period may be missed.
    wire convert_edge = cmd_s2_r & ~cmd_s3_r;

    // Stage pacing: one tick per oscillator period rounded down to whole cycles, restarted on convert
    logic [2:0] stage_cnt_r, stage_cnt_nxt;
    wire stage_tick = (stage_cnt_r == 3'(`SADC_STAGE_CYC - 1));
    assign stage_cnt_nxt = (convert_edge | stage_tick) ? 3'h0 : stage_cnt_r + 3'h1;

    logic [2:0] shift_r, shift_nxt;
    // Marker enters stage 0 on convert and walks three stages
    assign shift_nxt = convert_edge ? 3'h1 : (stage_tick ? {shift_r[1:0], 1'b0} : shift_r);

    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
        begin
            stage_cnt_r <= 3'h0;
            shift_r <= 3'h0;
        end
        else
        begin
            stage_cnt_r <= stage_cnt_nxt;
            shift_r <= shift_nxt;
        end
    end

    wire coarse_strobe = shift_r[0] & stage_tick;
    wire fine_strobe = shift_r[1] & stage_tick;
    wire merge_strobe = shift_r[2] & stage_tick;

    // Gate opens once the fixed conversion interval has run out
    logic [2:0] conv_cnt_r, conv_cnt_nxt;
    logic gate_r, gate_nxt;
    wire conv_done = (conv_cnt_r == 3'(`SADC_CONV_CYC - 1));
    logic counting_r;
    assign conv_cnt_nxt = convert_edge ? 3'h0 : (counting_r ? conv_cnt_r + 3'h1 : conv_cnt_r);
    wire gate_open = counting_r & conv_done;
    assign gate_nxt = convert_edge ? 1'b0 : (gate_open ? 1'b1 : gate_r);

    logic blank_r, blank_nxt;
    assign blank_nxt = gate_open ? 1'b1 : (coarse_strobe ? 1'b0 : blank_r);

    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
        begin
            conv_cnt_r <= 3'h0;
            counting_r <= 1'b0;
            gate_r <= 1'b0;
            blank_r <= 1'b0;
        end
        else
        begin
            conv_cnt_r <= conv_cnt_nxt;
            counting_r <= convert_edge | (counting_r & ~conv_done);
            gate_r <= gate_nxt;
            blank_r <= blank_nxt;
        end
    end

    assign SH_GATE = gate_r;
    assign BLANK = blank_r;

    // Holding latches, merge latch and adder
    sadc_code_type coarse_r, fine_r;
    logic [13:0] merge_r;
    logic merge_vld_r;
    sadc_word_type sum_r;
    logic sum_vld_r;

    wire [11:0] opnd_hi = {merge_r[13:7], 5'h00};
    wire [11:0] opnd_lo = {5'h00, merge_r[6:0]};
    wire [12:0] raw_sum = {1'b0, opnd_hi} + {1'b0, opnd_lo};
    // Saturate rather than let an overrange fold back to small codes
    wire [11:0] sat_sum = raw_sum[12] ? `SADC_ALL_ONES : raw_sum[11:0];

    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
        begin
            coarse_r <= 7'h00;
            fine_r <= 7'h00;
            merge_r <= 14'h0000;
            merge_vld_r <= 1'b0;
            sum_r <= 12'h000;
            sum_vld_r <= 1'b0;
        end
        else
        begin
            if (coarse_strobe)
                coarse_r <= coarse_s2_r;
            if (fine_strobe)
                fine_r <= fine_s2_r;
            if (merge_strobe)
                merge_r <= {coarse_r, fine_r};
            merge_vld_r <= merge_strobe;
            if (merge_vld_r)
                sum_r <= sat_sum;
            if (merge_vld_r)
                sum_vld_r <= 1'b1;
            else if (convert_edge)
                sum_vld_r <= 1'b0;
        end
    end

    // Latency line advances once per convert command
    sadc_word_type pipe_r [0:2];
    logic [2:0] pipe_vld_r;
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
        begin
            pipe_r[0] <= 12'h000;
            pipe_r[1] <= 12'h000;
            pipe_r[2] <= 12'h000;
            pipe_vld_r <= 3'h0;
        end
        else if (convert_edge)
        begin
            pipe_r[0] <= sum_r;
            pipe_r[1] <= pipe_r[0];
            pipe_r[2] <= pipe_r[1];
            pipe_vld_r <= {pipe_vld_r[1:0], sum_vld_r};
        end
    end

    // Code 0 is one period, 1 two, 2 and 3 three
    wire [1:0] tap = (lat_s2_r == 2'h3) ? 2'h2 : lat_s2_r;
    wire [11:0] tap_word = pipe_r[tap];
    wire tap_vld = pipe_vld_r[tap];
    wire [11:0] coded_word = inv_s2_r ? ~tap_word : tap_word;

    // Emit one cycle after the line shifts, so the tap is settled
    logic emit_r;
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
            emit_r <= 1'b0;
        else
            emit_r <= convert_edge;
    end

    // Two-entry buffer; a stalled latch backs up here, not on the wire
    sadc_word_type buf_r [0:`SADC_BUF_DEPTH-1];
    logic wr_ptr_r, rd_ptr_r;
    logic [1:0] count_r, count_nxt;
    logic ready_r;
    wire buf_full = (count_r == 2'(`SADC_BUF_DEPTH));
    wire buf_valid = (count_r != 2'h0);
    wire push = emit_r & tap_vld & ~buf_full;
    logic pop;
    assign count_nxt = count_r + {1'b0, push} - {1'b0, pop};

    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
        begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r <= 2'h0;
            ready_r <= 1'b1;
        end
        else
        begin
            if (push)
            begin
                buf_r[wr_ptr_r] <= coded_word;
                wr_ptr_r <= ~wr_ptr_r;
            end
            if (pop)
                rd_ptr_r <= ~rd_ptr_r;
            count_r <= count_nxt;
            ready_r <= (count_nxt != 2'(`SADC_BUF_DEPTH));
        end
    end

    assign WORD_ACCEPT_READY = ready_r;

    // Toggle handshake; hold register is stable while a request is open
    logic req_tgl_r, pending_r;
    sadc_word_type hold_r;
    logic ack_s1_r, ack_s2_r, ack_s3_r;
    logic link_ack_tgl_r;
    wire ack_event = ack_s2_r ^ ack_s3_r;
    assign pop = buf_valid & ~pending_r;

    always_ff @(posedge CLOCK)
    begin
        ack_s1_r <= link_ack_tgl_r;
        ack_s2_r <= ack_s1_r;
        if (SYS_RST)
        begin
            ack_s3_r <= 1'b0;
            req_tgl_r <= 1'b0;
            pending_r <= 1'b0;
            hold_r <= 12'h000;
        end
        else
        begin
            ack_s3_r <= ack_s2_r;
            if (pop)
            begin
                hold_r <= buf_r[rd_ptr_r];
                req_tgl_r <= ~req_tgl_r;
                pending_r <= 1'b1;
            end
            else if (ack_event)
                pending_r <= 1'b0;
        end
    end

    // Link domain: reset, request and latch-ready synchronisers
    logic lrst_s1_r, lrst_s2_r;
    logic req_s1_r, req_s2_r, req_s3_r;
    logic rdy_s1_r, rdy_s2_r;
    always_ff @(posedge LINK_CLK)
    begin
        lrst_s1_r <= SYS_RST;
        lrst_s2_r <= lrst_s1_r;
        req_s1_r <= req_tgl_r;
        req_s2_r <= req_s1_r;
        rdy_s1_r <= LATCH_READY;
        rdy_s2_r <= rdy_s1_r;
    end

    sadc_link_state_type lk_state_r, lk_state_nxt;
    wire req_event = req_s2_r ^ req_s3_r;
    logic req_seen_r;

    always_comb
    begin
        lk_state_nxt = lk_state_r;
        unique case (lk_state_r)
            LK_IDLE:
                if (req_seen_r & rdy_s2_r)
                    lk_state_nxt = LK_DRIVE;
            LK_DRIVE:
                lk_state_nxt = LK_STROBE;
            LK_STROBE:
                lk_state_nxt = LK_DONE;
            LK_DONE:
                lk_state_nxt = LK_IDLE;
        endcase
    end

    sadc_word_type data_r;
    logic strobe_r;
    always_ff @(posedge LINK_CLK)
    begin
        if (lrst_s2_r)
        begin
            req_s3_r <= 1'b0;
            req_seen_r <= 1'b0;
            lk_state_r <= LK_IDLE;
            data_r <= 12'h000;
            strobe_r <= 1'b0;
            link_ack_tgl_r <= 1'b0;
        end
        else
        begin
            req_s3_r <= req_s2_r;
            lk_state_r <= lk_state_nxt;
            if (req_event)
                req_seen_r <= 1'b1;
            else if (lk_state_r == LK_DONE)
                req_seen_r <= 1'b0;
            // Data first; strobe a full link period later covers set-up
            if (lk_state_r == LK_IDLE && lk_state_nxt == LK_DRIVE)
                data_r <= hold_r;
            strobe_r <= (lk_state_r == LK_DRIVE);
            if (lk_state_r == LK_DONE)
                link_ack_tgl_r <= ~link_ack_tgl_r;
        end
    end

    assign DATA_OUT = data_r;
    assign WORD_READY_STROBE = strobe_r;
endmodule

`default_nettype wire

// [testbench/sadc_core_sva.sv]
// Port-level checks on the converter correction core.
// Bound to every sadc_core; sees only its ports, both clock domains.
`timescale 1ns/100ps
`default_nettype none
module sadc_core_sva
(
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic LINK_CLK,
    input wire logic CONVERT_CMD,
    input wire logic LATCH_READY,
    input wire logic SH_GATE,
    input wire logic BLANK,
    input wire sadc_pkg::sadc_word_type DATA_OUT,
    input wire logic WORD_READY_STROBE
);
    import sadc_pkg::*;
    // Hold phase of two or three cycles, then acquisition
    sequence s_hold_then_acq;
        ##1 !SH_GATE ##[1:2] SH_GATE;
    endsequence
    a_gate_on_cmd: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        $rose(CONVERT_CMD) |-> ##[1:4] !SH_GATE) else $error("gate kept high after convert");
    a_fall_needs_cmd: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        $fell(SH_GATE) |-> $past(CONVERT_CMD, 2)) else $error("gate fell without convert");
    a_conv_interval: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        $fell(SH_GATE) |-> s_hold_then_acq) else $error("hold interval wrong");
    a_blank_in_acq: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        SH_GATE && $past(SH_GATE) |-> BLANK) else $error("no blanking in acquisition");
    a_blank_drops: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        $fell(SH_GATE) |-> ##[0:3] !BLANK) else $error("blanking not released");
    a_strobe_pulse: assert property (@(posedge LINK_CLK) disable iff (SYS_RST)
        $rose(WORD_READY_STROBE) |=> !WORD_READY_STROBE) else $error("strobe too long");
    a_data_settled: assert property (@(posedge LINK_CLK) disable iff (SYS_RST)
        WORD_READY_STROBE |-> $stable(DATA_OUT) ##1 $stable(DATA_OUT))
        else $error("data moved around strobe");
    a_hold_unready: assert property (@(posedge LINK_CLK) disable iff (SYS_RST)
        (!LATCH_READY)[*5] |-> !WORD_READY_STROBE) else $error("word sent to busy latch");
endmodule
bind sadc_core sadc_core_sva sadc_core_sva_i
(
    .CLOCK(CLOCK),
    .SYS_RST(SYS_RST),
    .LINK_CLK(LINK_CLK),
    .CONVERT_CMD(CONVERT_CMD),
    .LATCH_READY(LATCH_READY),
    .SH_GATE(SH_GATE),
    .BLANK(BLANK),
    .DATA_OUT(DATA_OUT),
    .WORD_READY_STROBE(WORD_READY_STROBE)
);
`default_nettype wire

// [testbench/sadc_latch_model.sv]
// External word latch on the link clock.
// Assumes the bench commands stalls; sixteen slots, wrapping after that.
`timescale 1ns/100ps
`default_nettype none
module sadc_latch_model
(
    input wire logic link_clk,
    input wire logic rst,
    input wire logic stall,
    input wire sadc_pkg::sadc_word_type data_out,
    input wire logic strobe,
    output logic latch_ready
);
    import sadc_pkg::*;
    sadc_word_type words [0:15];
    int count = 0;
    // Ready comes from this one process only; low while reset is held
    always @(posedge link_clk)
    begin
        latch_ready <= !stall && !rst;
        if (rst)
            count <= 0;
        else if (strobe)
        begin
            words[count[3:0]] <= data_out;
            count <= count + 1;
        end
    end
endmodule
`default_nettype wire

// [testbench/sadc_core_tb_top.sv]
// Self-checking bench for the converter correction core.
// Convert source and codes driven on CLOCK; latch model on LINK_CLK.
`timescale 1ns/100ps
`default_nettype none
module sadc_core_tb_top;
    import sadc_pkg::*;
    logic CLOCK = 1'b0;
    logic LINK_CLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic CONVERT_CMD = 1'b0;
    sadc_code_type COARSE_CODE = 7'h00;
    sadc_code_type FINE_CODE = 7'h00;
    sadc_lat_type LATENCY_SEL = 2'h0;
    logic OUTPUT_INVERT = 1'b0;
    logic stall = 1'b0;
    logic LATCH_READY, SH_GATE, BLANK, WORD_ACCEPT_READY, WORD_READY_STROBE;
    sadc_word_type DATA_OUT;
    sadc_word_type exp_q [$];
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;
    logic saw_full = 1'b0;
    initial forever #20 CLOCK = ~CLOCK;
    initial
    begin
        #3;
        forever #6 LINK_CLK = ~LINK_CLK;
    end
    sadc_core sadc_core_i (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .LINK_CLK(LINK_CLK),
        .CONVERT_CMD(CONVERT_CMD), .COARSE_CODE(COARSE_CODE), .FINE_CODE(FINE_CODE),
        .LATENCY_SEL(LATENCY_SEL), .OUTPUT_INVERT(OUTPUT_INVERT), .LATCH_READY(LATCH_READY),
        .SH_GATE(SH_GATE), .BLANK(BLANK), .WORD_ACCEPT_READY(WORD_ACCEPT_READY),
        .DATA_OUT(DATA_OUT), .WORD_READY_STROBE(WORD_READY_STROBE));
    sadc_latch_model sadc_latch_model_i (.link_clk(LINK_CLK), .rst(SYS_RST), .stall(stall),
        .data_out(DATA_OUT), .strobe(WORD_READY_STROBE), .latch_ready(LATCH_READY));
    task automatic give_verdict();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check_word(input sadc_word_type got, input sadc_word_type exp);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    function automatic sadc_word_type exp_word(input sadc_code_type c, input sadc_code_type f);
        logic [12:0] s;
        s = {1'b0, c, 5'h00} + {6'h00, f};
        if (s[12])
            s = 13'h0FFF;
        return OUTPUT_INVERT ? ~s[11:0] : s[11:0];
    endfunction
    task automatic reset_dut(input sadc_lat_type lat, input logic inv);
        @(posedge CLOCK);
        #1 SYS_RST = 1'b1;
        LATENCY_SEL = lat;
        OUTPUT_INVERT = inv;
        repeat (8) @(posedge CLOCK);
        #1 SYS_RST = 1'b0;
        exp_q.delete();
        repeat (4) @(posedge CLOCK);
    endtask
    // Ten-cycle period, pulse three cycles wide, codes held all period
    task automatic convert(input sadc_code_type c, input sadc_code_type f);
        @(posedge CLOCK);
        #1 CONVERT_CMD = 1'b1;
        COARSE_CODE = c;
        FINE_CODE = f;
        repeat (3) @(posedge CLOCK);
        #1 CONVERT_CMD = 1'b0;
        repeat (6) @(posedge CLOCK);
    endtask
    task automatic send(input sadc_code_type c, input sadc_code_type f);
        exp_q.push_back(exp_word(c, f));
        convert(c, f);
    endtask
    task automatic flush(input int n);
        repeat (n) convert(7'h00, 7'h00);
    endtask
    task automatic drain_check(input int n);
        for (int i = 0; i < 400 && sadc_latch_model_i.count < n; i++) @(posedge CLOCK);
        check_bit(sadc_latch_model_i.count >= n, 1'b1);
        for (int i = 0; i < n; i++) check_word(sadc_latch_model_i.words[i], exp_q[i]);
    endtask
    task automatic test_reset();
        reset_dut(2'h0, 1'b0);
        check_word(DATA_OUT, 12'h000);
        check_bit(WORD_READY_STROBE, 1'b0);
        check_bit(WORD_ACCEPT_READY, 1'b1);
        check_bit(SH_GATE, 1'b0);
    endtask
    task automatic test_sum();
        reset_dut(2'h0, 1'b0);
        send(7'h00, 7'h00);
        send(7'h01, 7'h7F);
        send(7'h40, 7'h10);
        send(7'h7F, 7'h1F);
        send(7'h7F, 7'h20);
        send(7'h7E, 7'h7F);
        flush(1);
        drain_check(6);
    endtask
    task automatic test_invert();
        reset_dut(2'h0, 1'b1);
        send(7'h12, 7'h05);
        send(7'h7F, 7'h40);
        flush(1);
        drain_check(2);
    endtask
    // Word count before flushing shows how many periods each word lags
    task automatic test_latency();
        int lag;
        for (int k = 0; k < 4; k++)
        begin
            lag = (k == 0) ? 1 : (k == 1) ? 2 : 3;
            reset_dut(sadc_lat_type'(k), 1'b0);
            send(7'h05, 7'h03);
            send(7'h2A, 7'h11);
            send(7'h33, 7'h44);
            repeat (4) @(posedge CLOCK);
            check_bit(sadc_latch_model_i.count == 3 - lag, 1'b1);
            flush(lag);
            drain_check(3);
        end
    endtask
    // Stalled latch: buffer fills and refuses, survivors drain in order
    task automatic test_stall();
        int n;
        reset_dut(2'h0, 1'b0);
        #1 stall = 1'b1;
        saw_full = 1'b0;
        for (int i = 0; i < 6; i++) send(7'(8 * i), 7'(i + 1));
        check_bit(sadc_latch_model_i.count == 0, 1'b1);
        check_bit(saw_full, 1'b1);
        #1 stall = 1'b0;
        repeat (100) @(posedge CLOCK);
        n = sadc_latch_model_i.count;
        check_bit(n >= 2 && n <= 5, 1'b1);
        drain_check(n);
        check_bit(WORD_ACCEPT_READY, 1'b1);
    endtask
    always @(posedge CLOCK)
    begin
        cycles++;
        if (!SYS_RST && WORD_ACCEPT_READY === 1'b0)
            saw_full = 1'b1;
        if (cycles == 5000)
        begin
            failures++;
            give_verdict();
        end
    end
    initial
    begin
        test_reset();
        test_sum();
        test_invert();
        test_latency();
        test_stall();
        give_verdict();
    end
endmodule
`default_nettype wire
